// *** hw/dffrc_cfg.svh ***
/*
 * Constants for the clearable D storage register banks: widths,
 * synchroniser depth and reset values.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef DFFRC_CFG_SVH
`define DFFRC_CFG_SVH

`define DFFRC_HEX_WIDTH 6
`define DFFRC_QUAD_WIDTH 4
`define DFFRC_SYNC_STAGES 3
`define DFFRC_HEX_RESET 6'h00
`define DFFRC_QUAD_RESET 4'h0
`define DFFRC_CLK_PERIOD_NS 5
`define DFFRC_PIN_LATENCY_CYCLES 3

`endif

// *** hw/dffrc_pkg.sv ***
/*
 * Types shared by the register bank modules.
 * Assumes dffrc_cfg.svh is on the include path.
 */
`include "dffrc_cfg.svh"

package dffrc_pkg;
    typedef logic [`DFFRC_HEX_WIDTH-1:0] dffrc_hex_t;
    typedef logic [`DFFRC_QUAD_WIDTH-1:0] dffrc_quad_t;
endpackage : dffrc_pkg

// *** hw/dffrc_sync.sv ***
/*
 * Three-stage pin synchroniser with agreement filter: a bit of the
 * filtered output follows only when the second and third stages agree.
 * Assumes a single clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "dffrc_cfg.svh"

module dffrc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else if (clk_en_in) begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_filter
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    level_reg[i] <= 1'b0;
                end else if (clk_en_in && (stage2_reg[i] == stage3_reg[i])) begin
                    level_reg[i] <= stage3_reg[i];
                end
            end
        end
    endgenerate

    assign level_out = level_reg;
endmodule : dffrc_sync

// *** hw/dffrc_top.sv ***
/*
 * Two banks of edge-loaded D storage flip-flops, each bank with its own common clear:
 * a six-wide bank with true outputs and a four-wide bank with true and
 * complementary outputs. Bank clock, clear and data arrive as pins.
 * Assumes clock_in far faster than the bank clocks; bank pins are
 * asynchronous to clock_in and are filtered before use, though the raw clear also gates the outputs.
 */
// Summary of operation
// RULE_01: Rising bank clock loads data while clear high
// RULE_02: Clear low forces Q low, complement high
// RULE_03: Steady bank clock leaves outputs unchanged
// RULE_04: Six-wide bank has true outputs only
// RULE_05: Four-wide bank has true and complement outputs
// RULE_06: Own data per flop, shared clock, clear
// RULE_07: Clear beats coincident edge; next edge loads
`timescale 1ns/1ps
`include "dffrc_cfg.svh"

module dffrc_top (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic hex_bank_clk_in,
    input wire logic hex_clear_n_in,
    input wire dffrc_pkg::dffrc_hex_t hex_d_in,
    output dffrc_pkg::dffrc_hex_t hex_q_out,
    input wire logic quad_bank_clk_in,
    input wire logic quad_clear_n_in,
    input wire dffrc_pkg::dffrc_quad_t quad_d_in,
    output dffrc_pkg::dffrc_quad_t quad_q_out,
    output dffrc_pkg::dffrc_quad_t quad_q_n_out
);
    import dffrc_pkg::*;

    localparam int HEX_PINS = `DFFRC_HEX_WIDTH + 2;
    localparam int QUAD_PINS = `DFFRC_QUAD_WIDTH + 2;

    function automatic logic rising(input logic now_level, input logic was_level);
        rising = now_level & ~was_level;
    endfunction : rising

    logic [HEX_PINS-1:0] hex_level;
    logic [QUAD_PINS-1:0] quad_level;
    logic hex_clk_prev_reg;
    logic quad_clk_prev_reg;
    logic hex_load;
    logic quad_load;
    logic hex_clear_active;
    logic quad_clear_active;
    dffrc_hex_t hex_d_level;
    dffrc_quad_t quad_d_level;
    dffrc_hex_t hex_store_reg;
    dffrc_quad_t quad_store_reg;

    // Clock, clear and data pass one filter so their delays stay matched
    dffrc_sync #(
        .WIDTH(HEX_PINS)
    ) u_hex_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .pin_in({hex_bank_clk_in, hex_clear_n_in, hex_d_in}),
        .level_out(hex_level)
    );

    dffrc_sync #(
        .WIDTH(QUAD_PINS)
    ) u_quad_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .pin_in({quad_bank_clk_in, quad_clear_n_in, quad_d_in}),
        .level_out(quad_level)
    );

    assign hex_d_level = hex_level[`DFFRC_HEX_WIDTH-1:0];
    assign quad_d_level = quad_level[`DFFRC_QUAD_WIDTH-1:0];
    assign hex_clear_active = ~hex_level[HEX_PINS-2];
    assign quad_clear_active = ~quad_level[QUAD_PINS-2];

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            hex_clk_prev_reg <= 1'b0;
        end else if (clk_en_in) begin
            hex_clk_prev_reg <= hex_level[HEX_PINS-1];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            quad_clk_prev_reg <= 1'b0;
        end else if (clk_en_in) begin
            quad_clk_prev_reg <= quad_level[QUAD_PINS-1];
        end
    end

    // Only a low-to-high step of the filtered bank clock loads
    assign hex_load = rising(hex_level[HEX_PINS-1], hex_clk_prev_reg); // [RULE_03]
    assign quad_load = rising(quad_level[QUAD_PINS-1], quad_clk_prev_reg); // [RULE_03]

    genvar i;
    generate
        for (i = 0; i < `DFFRC_HEX_WIDTH; i++) begin : g_hex_flop
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    hex_store_reg[i] <= 1'b0;
                end else if (clk_en_in) begin
                    if (hex_clear_active) begin
                        hex_store_reg[i] <= 1'b0; // [RULE_07] [RULE_02]
                    end else if (hex_load) begin
                        hex_store_reg[i] <= hex_d_level[i]; // [RULE_01] [RULE_06]
                    end
                end
            end
        end
        for (i = 0; i < `DFFRC_QUAD_WIDTH; i++) begin : g_quad_flop
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    quad_store_reg[i] <= 1'b0;
                end else if (clk_en_in) begin
                    if (quad_clear_active) begin
                        quad_store_reg[i] <= 1'b0; // [RULE_07] [RULE_02]
                    end else if (quad_load) begin
                        quad_store_reg[i] <= quad_d_level[i]; // [RULE_01] [RULE_06]
                    end
                end
            end
        end
    endgenerate

    // Raw clear gates the outputs so a clear shows at once, not after the filter
    assign hex_q_out = hex_clear_n_in ? hex_store_reg : `DFFRC_HEX_RESET; // [RULE_02] [RULE_04]
    assign quad_q_out = quad_clear_n_in ? quad_store_reg : `DFFRC_QUAD_RESET; // [RULE_02]
    assign quad_q_n_out = ~quad_q_out; // [RULE_05]
endmodule : dffrc_top

// *** tb/dffrc_checker.sv ***
/* Port assertions for the bank register top; assumes the bind below. */
`timescale 1ns/1ps
module dffrc_checker (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic hex_bank_clk_in,
    input wire logic hex_clear_n_in,
    input wire logic [5:0] hex_d_in,
    input wire logic [5:0] hex_q_out,
    input wire logic quad_bank_clk_in,
    input wire logic quad_clear_n_in,
    input wire logic [3:0] quad_d_in,
    input wire logic [3:0] quad_q_out,
    input wire logic [3:0] quad_q_n_out
);
    import dffrc_pkg::*;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    a_hex_load: assert property (
        ($rose(hex_bank_clk_in) && clk_en_in) ##0 hex_clear_n_in[*6]
        |-> hex_q_out == $past(hex_d_in, 5)) else $error("hex load wrong");
    a_quad_load: assert property (
        ($rose(quad_bank_clk_in) && clk_en_in) ##0 quad_clear_n_in[*6]
        |-> quad_q_out == $past(quad_d_in, 5)) else $error("quad load wrong");
    a_hex_clear: assert property (
        !hex_clear_n_in |-> hex_q_out == 6'h00) else $error("hex clear wrong");
    a_quad_clear: assert property (
        !quad_clear_n_in |-> quad_q_n_out == 4'hF) else $error("quad clear wrong");
    a_quad_comp: assert property (
        quad_q_n_out == ~quad_q_out) else $error("complement wrong");
    a_steady_hold: assert property (
        (!rst_in && hex_clear_n_in && $stable(hex_bank_clk_in))[*7]
        |-> $stable(hex_q_out)) else $error("hex changed without edge");
    a_clear_wins: assert property (
        ($rose(hex_bank_clk_in) && !hex_clear_n_in) ##1 hex_clear_n_in[*5]
        |-> hex_q_out == 6'h00) else $error("edge beat clear");
    cover property ($rose(hex_bank_clk_in) && hex_clear_n_in);
    cover property ($fell(quad_clear_n_in));
    cover property ($rose(quad_bank_clk_in) && !quad_clear_n_in);
endmodule : dffrc_checker
bind dffrc_top dffrc_checker chk (.clock_in, .rst_in, .clk_en_in, .hex_bank_clk_in,
    .hex_clear_n_in, .hex_d_in, .hex_q_out, .quad_bank_clk_in, .quad_clear_n_in,
    .quad_d_in, .quad_q_out, .quad_q_n_out);

// *** tb/dffrc_partner.sv ***
/* Bank clock source; assumes go pulses spaced beyond one high phase. */
`timescale 1ns/1ps
module dffrc_partner (
    input wire logic clock_in,
    input wire logic go_in,
    output logic bank_clk_out
);
    logic [3:0] cnt_reg = 4'h0;
    // Eight-cycle high phase, four times the filter's minimum
    always_ff @(negedge clock_in) begin
        cnt_reg <= go_in ? 4'h8 : (cnt_reg == 4'h0 ? 4'h0 : cnt_reg - 4'h1);
    end
    assign bank_clk_out = (cnt_reg != 4'h0);
endmodule : dffrc_partner

// *** tb/tb_dffrc_top.sv ***
/* Bench for both banks; assumes the partner clock and the bound checker. */
`timescale 1ns/1ps
module tb_dffrc_top;
    import dffrc_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic clr_n = 1'b1;
    logic go = 1'b0;
    logic en = 1'b1;
    logic bclk;
    dffrc_hex_t hd = 6'h00;
    dffrc_hex_t hq;
    dffrc_quad_t qd = 4'h0;
    dffrc_quad_t qq;
    dffrc_quad_t qn;
    int miscompares = 0;
    int comparisons = 0;
    int cyc = 0;
    always #2.5 clock_in = ~clock_in;
    dffrc_partner drv (.clock_in(clock_in), .go_in(go), .bank_clk_out(bclk));
    dffrc_top uut (.clock_in(clock_in), .rst_in(rst_in), .clk_en_in(en),
        .hex_bank_clk_in(bclk), .hex_clear_n_in(clr_n), .hex_d_in(hd), .hex_q_out(hq),
        .quad_bank_clk_in(bclk), .quad_clear_n_in(clr_n), .quad_d_in(qd),
        .quad_q_out(qq), .quad_q_n_out(qn));
    task automatic chk(input logic ok);
        comparisons++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t bank output mismatch", $time);
        end
    endtask : chk
    task automatic pulse(input int lag);
        repeat (5) @(negedge clock_in);
        go <= 1'b1;
        @(negedge clock_in);
        go <= 1'b0;
        repeat (lag) @(negedge clock_in);
        clr_n <= 1'b1;
        repeat (20) @(negedge clock_in);
    endtask : pulse
    task automatic t_load(input dffrc_hex_t h, input dffrc_quad_t q);
        hd <= h;
        qd <= q;
        pulse(0);
        chk(hq === h);
        chk(qq === q && qn === ~q);
    endtask : t_load
    task automatic t_hold();
        hd <= 6'h00;
        qd <= 4'h0;
        repeat (12) @(negedge clock_in);
        chk(hq === 6'h3F && qq === 4'hF);
    endtask : t_hold
    task automatic t_freeze();
        en <= 1'b0;
        hd <= 6'h15;
        qd <= 4'hA;
        pulse(0);
        en <= 1'b1;
        repeat (10) @(negedge clock_in);
        chk(hq === 6'h3F && qq === 4'hF && qn === 4'h0);
    endtask : t_freeze
    task automatic t_clear();
        clr_n <= 1'b0;
        #1;
        chk(hq === 6'h00 && qq === 4'h0 && qn === 4'hF);
        repeat (8) @(negedge clock_in);
    endtask : t_clear
    task automatic t_coincide();
        hd <= 6'h2A;
        qd <= 4'h5;
        pulse(1);
        chk(hq === 6'h00 && qq === 4'h0);
        t_load(6'h2A, 4'h5);
    endtask : t_coincide
    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 1000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(negedge clock_in);
        rst_in <= 1'b0;
        repeat (8) @(negedge clock_in);
        t_load(6'h2A, 4'h5);
        t_load(6'h15, 4'hA);
        t_load(6'h3F, 4'hF);
        t_hold();
        t_freeze();
        t_clear();
        t_coincide();
        summarize();
    end
endmodule : tb_dffrc_top
